/* File: include/uep_pkg.sv */
// constants and register layout of the endpoint transmit engine
package uep_pkg;
	localparam int          ADDR_W          = 9;
	localparam int          MEM_WORDS       = 256;
	localparam int          NUM_EP          = 8;
	localparam int          CNT_W           = 10;
	localparam int          ENGINE_CLK_MHZ  = 48;
	localparam int          MIN_BUS_CLK_MHZ = 8;
	localparam int          REF_CLK_MHZ     = 100;
	localparam int          RESET_SVC_MS    = 10;
	localparam logic [8:0]  REG_EP_BASE     = 9'h100;
	localparam logic [8:0]  REG_FN          = 9'h108;
	localparam logic [8:0]  REG_DESC        = 9'h109;
	localparam logic [8:0]  REG_ISTR        = 9'h10A;
	localparam int          EPC_ADDR_LSB    = 0;
	localparam int          EPC_STATE_LSB   = 4;
	localparam int          EPC_TOG         = 6;
	localparam int          EPC_FLAG        = 7;
	localparam int          EPC_CLASS_LSB   = 8;
	localparam int          EPC_FEAT        = 10;
	localparam logic [15:0] EPC_RESET       = 16'h0000;
	localparam logic [15:0] EPC_WR_MASK     = 16'h07FF;
	localparam logic [1:0]  ST_DISABLED     = 2'h0;
	localparam logic [1:0]  ST_STALL        = 2'h1;
	localparam logic [1:0]  ST_NAK          = 2'h2;
	localparam logic [1:0]  ST_VALID        = 2'h3;
	localparam logic [1:0]  CLASS_CONTROL   = 2'h1;
	localparam int          FN_EN           = 7;
	localparam logic [7:0]  FN_RESET        = 8'h00;
	localparam int          ISTR_DIR        = 4;
	localparam int          ISTR_CTR        = 5;
	localparam int          ISTR_RST        = 6;
	localparam logic [15:0] DESC_MASK       = 16'hFFF8;
	localparam logic [15:0] DESC_RESET      = 16'h0000;
	localparam logic [7:0]  DESC_TX_PTR     = 8'h00;
	localparam logic [7:0]  DESC_TX_CNT     = 8'h01;
	localparam logic [7:0]  PID_DATA0       = 8'hC3;
	localparam logic [7:0]  PID_DATA1       = 8'h4B;
	localparam logic [7:0]  PID_ACK         = 8'hD2;
	localparam logic [7:0]  PID_NAK         = 8'h5A;
	localparam logic [7:0]  PID_STALL       = 8'h1E;
	localparam logic [15:0] CRC_INIT        = 16'hFFFF;
	localparam logic [15:0] CRC_POLY        = 16'hA001;
	localparam logic [15:0] HOST_DESC_BASE  = 16'h0000;
	localparam logic [15:0] HOST_BUF0_PTR   = 16'h0040;
	localparam logic [7:0]  HOST_TIMEOUT    = 8'h40;
endpackage

/* File: include/usb_link_if.sv */
// link between the endpoint engine and the token-issuing host end
interface usb_link_if;
	logic        bus_reset;
	logic        tok_in_valid;
	logic [6:0]  tok_addr;
	logic [3:0]  tok_ep;
	logic        hs_ack;
	logic        tx_valid;
	logic [7:0]  tx_byte;
	logic        tx_last;
	logic [8:0]  sw_addr;
	logic [15:0] sw_wdata;
	logic        sw_we;
	logic        sw_re;
	logic [15:0] sw_rdata;
	modport dev_end (
		input  bus_reset, tok_in_valid, tok_addr, tok_ep, hs_ack,
		input  sw_addr, sw_wdata, sw_we, sw_re,
		output tx_valid, tx_byte, tx_last, sw_rdata
	);
	modport host_end (
		output bus_reset, tok_in_valid, tok_addr, tok_ep, hs_ack,
		output sw_addr, sw_wdata, sw_we, sw_re,
		input  tx_valid, tx_byte, tx_last, sw_rdata
	);
endinterface

/* File: hdl/usb_ep_device.sv */
// endpoint registers, packet memory, arbiter and IN transmit engine
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
module usb_ep_device (
	input  wire logic   i_ref_clk,
	input  wire logic   i_rst,
	input  wire logic   i_ce,
	usb_link_if.dev_end link,
	output logic        o_ep_irq
);
	typedef enum logic [8:0] {
		st_idle     = 9'h001,
		st_desc_ptr = 9'h002,
		st_desc_cnt = 9'h004,
		st_fetch    = 9'h008,
		st_pid      = 9'h010,
		st_data     = 9'h020,
		st_crc_lo   = 9'h040,
		st_crc_hi   = 9'h080,
		st_wait_ack = 9'h100
	} eng_state_type;

	logic [15:0]   pkt_mem [0:uep_pkg::MEM_WORDS-1];
	logic [15:0]   endpoint_ctrl_reg [0:uep_pkg::NUM_EP-1];
	logic [15:0]   next_ctrl [0:uep_pkg::NUM_EP-1];
	logic [7:0]    function_number_reg;
	logic [15:0]   descriptor_table_base;
	logic          rst_flag;
	logic          phase;
	eng_state_type state;
	logic          rd_pend;
	logic          pid_sent;
	logic          byte_hi;
	logic [15:0]   tx_ptr;
	logic [15:0]   tx_cnt;
	logic [15:0]   word;
	logic [15:0]   crc;
	logic [15:0]   eng_q;
	logic [2:0]    ep_sel;
	logic          hit;
	logic [2:0]    hit_idx;
	logic          ctr_any;
	logic [2:0]    ctr_idx;

	// software decode
	wire        sw_acc  = link.sw_we | link.sw_re;
	wire        sw_mem  = sw_acc & ~link.sw_addr[8];
	wire        ep_sel_sw = link.sw_addr[8:3] == uep_pkg::REG_EP_BASE[8:3];
	wire        ctrl_we = link.sw_we & ep_sel_sw;
	wire        fn_we   = link.sw_we & (link.sw_addr == uep_pkg::REG_FN);
	wire        desc_we = link.sw_we & (link.sw_addr == uep_pkg::REG_DESC);
	wire        istr_we = link.sw_we & (link.sw_addr == uep_pkg::REG_ISTR);
	wire [15:0] istr_val = {9'h000, rst_flag, ctr_any, 1'b0, 1'b0, ctr_idx};
	wire [15:0] reg_val =
		ep_sel_sw ? endpoint_ctrl_reg[link.sw_addr[2:0]] :
		(link.sw_addr == uep_pkg::REG_FN) ? {8'h00, function_number_reg} :
		(link.sw_addr == uep_pkg::REG_DESC) ? descriptor_table_base :
		(link.sw_addr == uep_pkg::REG_ISTR) ? istr_val : 16'h0000;

	// token match and selected endpoint fields
	wire       fn_on   = function_number_reg[uep_pkg::FN_EN];
	wire       tok_us  = link.tok_in_valid & fn_on &
		(link.tok_addr == function_number_reg[6:0]);
	wire       tok_hit = tok_us & hit;
	wire [1:0] hit_st  =
		endpoint_ctrl_reg[hit_idx][uep_pkg::EPC_STATE_LSB +: 2];
	wire       cur_tog = endpoint_ctrl_reg[ep_sel][uep_pkg::EPC_TOG];
	wire       done    = (state == st_wait_ack) & link.hs_ack;

	// engine memory request and arbitration
	wire       rd_state = (state == st_desc_ptr) | (state == st_desc_cnt) |
		(state == st_fetch);
	wire       eng_req  = rd_state & ~rd_pend;
	wire [7:0] desc_word = descriptor_table_base[8:1] + {3'h0, ep_sel, 2'h0};
	wire [7:0] eng_addr =
		(state == st_desc_ptr) ? desc_word + uep_pkg::DESC_TX_PTR :
		(state == st_desc_cnt) ? desc_word + uep_pkg::DESC_TX_CNT :
		tx_ptr[8:1];
	wire       eng_ack  = eng_req & (phase | ~sw_mem);
	wire [7:0] cur_byte = byte_hi ? word[15:8] : word[7:0];
	wire [15:0] crc_next = crc_byte(crc, cur_byte);

	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int b = 0; b < 8; b++) begin
			if (r[0] ^ d[b]) begin
				r = (r >> 1) ^ uep_pkg::CRC_POLY;
			end else begin
				r = r >> 1;
			end
		end
		return r;
	endfunction

	// endpoint lookup and pending completion index
	always_comb begin
		hit = 1'b0;
		hit_idx = 3'h0;
		ctr_any = 1'b0;
		ctr_idx = 3'h0;
		for (int i = uep_pkg::NUM_EP - 1; i >= 0; i--) begin
			if (endpoint_ctrl_reg[i][uep_pkg::EPC_STATE_LSB +: 2] !=
				uep_pkg::ST_DISABLED &&
				endpoint_ctrl_reg[i][3:0] == link.tok_ep) begin
				hit = 1'b1;
				hit_idx = 3'(i);
			end
			if (endpoint_ctrl_reg[i][uep_pkg::EPC_FLAG]) begin
				ctr_any = 1'b1;
				ctr_idx = 3'(i);
			end
		end
	end

	// endpoint control next values
	always_comb begin
		for (int i = 0; i < uep_pkg::NUM_EP; i++) begin
			next_ctrl[i] = endpoint_ctrl_reg[i];
			if (ctrl_we && link.sw_addr[2:0] == 3'(i)) begin
				next_ctrl[i] = link.sw_wdata & uep_pkg::EPC_WR_MASK;
				next_ctrl[i][uep_pkg::EPC_TOG] =
					endpoint_ctrl_reg[i][uep_pkg::EPC_TOG];
				next_ctrl[i][uep_pkg::EPC_FLAG] =
					endpoint_ctrl_reg[i][uep_pkg::EPC_FLAG] &
					link.sw_wdata[uep_pkg::EPC_FLAG];
			end
			if (done && ep_sel == 3'(i)) begin
				next_ctrl[i][uep_pkg::EPC_TOG] =
					~endpoint_ctrl_reg[i][uep_pkg::EPC_TOG];
				next_ctrl[i][uep_pkg::EPC_STATE_LSB +: 2] =
					uep_pkg::ST_NAK;
				next_ctrl[i][uep_pkg::EPC_FLAG] = 1'b1;
			end
			if (link.bus_reset) begin
				next_ctrl[i] = uep_pkg::EPC_RESET;
			end
		end
	end

	// packet memory, software and engine access in one cycle only while phase is high
	always_ff @(posedge i_ref_clk) begin
		if (i_ce) begin
			if (link.sw_we & sw_mem) begin
				pkt_mem[link.sw_addr[7:0]] <= link.sw_wdata;
			end
			if (eng_ack) begin
				eng_q <= pkt_mem[eng_addr];
			end
		end
	end

	// registers seen by software
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			function_number_reg <= uep_pkg::FN_RESET;
			descriptor_table_base <= uep_pkg::DESC_RESET;
			rst_flag <= 1'b0;
			phase <= 1'b0;
			link.sw_rdata <= 16'h0000;
			o_ep_irq <= 1'b0;
			for (int i = 0; i < uep_pkg::NUM_EP; i++) begin
				endpoint_ctrl_reg[i] <= uep_pkg::EPC_RESET;
			end
		end else if (i_ce) begin
			phase <= ~phase;
			o_ep_irq <= ctr_any;
			if (link.sw_re) begin
				link.sw_rdata <= sw_mem ? pkt_mem[link.sw_addr[7:0]] : reg_val;
			end
			for (int i = 0; i < uep_pkg::NUM_EP; i++) begin
				endpoint_ctrl_reg[i] <= next_ctrl[i];
			end
			if (link.bus_reset) begin
				function_number_reg <= uep_pkg::FN_RESET;
			end else if (fn_we) begin
				function_number_reg <= link.sw_wdata[7:0];
			end
			if (desc_we) begin
				descriptor_table_base <= link.sw_wdata & uep_pkg::DESC_MASK;
			end
			if (link.bus_reset) begin
				rst_flag <= 1'b1;
			end else if (istr_we & ~link.sw_wdata[uep_pkg::ISTR_RST]) begin
				rst_flag <= 1'b0;
			end
		end
	end

	// transmit engine, clocked by the reference clock with enable
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state <= st_idle;
			rd_pend <= 1'b0;
			pid_sent <= 1'b0;
			byte_hi <= 1'b0;
			tx_ptr <= 16'h0000;
			tx_cnt <= 16'h0000;
			word <= 16'h0000;
			crc <= uep_pkg::CRC_INIT;
			ep_sel <= 3'h0;
			link.tx_valid <= 1'b0;
			link.tx_byte <= 8'h00;
			link.tx_last <= 1'b0;
		end else if (i_ce) begin
			link.tx_valid <= 1'b0;
			link.tx_last <= 1'b0;
			if (link.bus_reset) begin
				state <= st_idle;
				rd_pend <= 1'b0;
			end else begin
				case (state)
					st_idle: begin
						if (tok_hit) begin
							ep_sel <= hit_idx;
							if (hit_st == uep_pkg::ST_VALID) begin
								state <= st_desc_ptr;
							end else begin
								link.tx_valid <= 1'b1;
								link.tx_last <= 1'b1;
								link.tx_byte <= (hit_st == uep_pkg::ST_STALL) ?
									uep_pkg::PID_STALL : uep_pkg::PID_NAK;
							end
						end
					end
					st_desc_ptr: begin
						if (rd_pend) begin
							tx_ptr <= eng_q;
							rd_pend <= 1'b0;
							state <= st_desc_cnt;
						end else if (eng_ack) begin
							rd_pend <= 1'b1;
						end
					end
					st_desc_cnt: begin
						if (rd_pend) begin
							tx_cnt <= {6'h00, eng_q[uep_pkg::CNT_W-1:0]};
							rd_pend <= 1'b0;
							pid_sent <= 1'b0;
							byte_hi <= 1'b0;
							state <= (eng_q[uep_pkg::CNT_W-1:0] == 10'h000) ?
								st_pid : st_fetch;
						end else if (eng_ack) begin
							rd_pend <= 1'b1;
						end
					end
					st_fetch: begin
						if (rd_pend) begin
							word <= eng_q;
							rd_pend <= 1'b0;
							state <= pid_sent ? st_data : st_pid;
						end else if (eng_ack) begin
							rd_pend <= 1'b1;
						end
					end
					st_pid: begin
						link.tx_valid <= 1'b1;
						link.tx_byte <= cur_tog ? uep_pkg::PID_DATA1 :
							uep_pkg::PID_DATA0;
						crc <= uep_pkg::CRC_INIT;
						pid_sent <= 1'b1;
						state <= st_data;
					end
					st_data: begin
						if (tx_cnt == 16'h0000) begin
							state <= st_crc_lo;
						end else begin
							link.tx_valid <= 1'b1;
							link.tx_byte <= cur_byte;
							crc <= crc_next;
							tx_cnt <= tx_cnt - 16'h0001;
							byte_hi <= ~byte_hi;
							if (byte_hi) begin
								tx_ptr <= tx_ptr + 16'h0002;
								if (tx_cnt != 16'h0001) begin
									state <= st_fetch;
								end
							end
						end
					end
					st_crc_lo: begin
						link.tx_valid <= 1'b1;
						link.tx_byte <= ~crc[7:0];
						state <= st_crc_hi;
					end
					st_crc_hi: begin
						link.tx_valid <= 1'b1;
						link.tx_byte <= ~crc[15:8];
						link.tx_last <= 1'b1;
						state <= st_wait_ack;
					end
					st_wait_ack: begin
						if (link.hs_ack | link.tok_in_valid) begin
							state <= st_idle;
						end
					end
					default: begin
						state <= st_idle;
					end
				endcase
			end
		end
	end
endmodule

/* File: hdl/usb_ep_host.sv */
// host end: issues tokens and acts as the endpoint driver software
module usb_ep_host (
	input  wire logic    i_ref_clk,
	input  wire logic    i_rst,
	input  wire logic    i_ce,
	usb_link_if.host_end link,
	input  wire logic    i_reset_req,
	input  wire logic    i_set_addr,
	input  wire logic [6:0] i_new_addr,
	input  wire logic    i_in_req,
	input  wire logic [3:0] i_in_ep,
	input  wire logic [9:0] i_len,
	input  wire logic    i_mem_we,
	input  wire logic [7:0] i_mem_addr,
	input  wire logic [15:0] i_mem_wdata,
	input  wire logic    i_refill_done,
	output logic         o_busy,
	output logic         o_rx_valid,
	output logic [7:0]   o_rx_byte,
	output logic [7:0]   o_pid,
	output logic         o_serviced
);
	typedef enum logic [7:0] {
		h_idle   = 8'h01,
		h_cfg    = 8'h02,
		h_data   = 8'h04,
		h_rd     = 8'h08,
		h_rdwait = 8'h10,
		h_clear  = 8'h20,
		h_refill = 8'h40,
		h_count  = 8'h80
	} host_state_type;

	host_state_type state;
	logic [2:0]     step;
	logic [6:0]     cur_addr;
	logic [3:0]     svc_ep;
	logic           first;
	logic [7:0]     wait_cnt;
	logic           nak_probe;

	wire [15:0] ctrl_base = {5'h00, 1'b0, uep_pkg::CLASS_CONTROL, 4'h0, 4'h0};
	wire [7:0]  desc_w = uep_pkg::HOST_DESC_BASE[8:1] + {2'h0, svc_ep, 2'h0};
	wire [15:0] svc_ctrl = ctrl_base | {12'h000, svc_ep};
	wire        mem_ok = (state == h_idle) | (state == h_refill);

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state <= h_idle;
			step <= 3'h0;
			cur_addr <= 7'h00;
			svc_ep <= 4'h0;
			first <= 1'b0;
			wait_cnt <= 8'h00;
			nak_probe <= 1'b0;
			link.bus_reset <= 1'b0;
			link.tok_in_valid <= 1'b0;
			link.tok_addr <= 7'h00;
			link.tok_ep <= 4'h0;
			link.hs_ack <= 1'b0;
			link.sw_addr <= 9'h000;
			link.sw_wdata <= 16'h0000;
			link.sw_we <= 1'b0;
			link.sw_re <= 1'b0;
			o_busy <= 1'b0;
			o_rx_valid <= 1'b0;
			o_rx_byte <= 8'h00;
			o_pid <= 8'h00;
			o_serviced <= 1'b0;
		end else if (i_ce) begin
			link.bus_reset <= 1'b0;
			link.tok_in_valid <= 1'b0;
			link.hs_ack <= 1'b0;
			link.sw_we <= 1'b0;
			link.sw_re <= 1'b0;
			o_rx_valid <= 1'b0;
			o_serviced <= 1'b0;
			if (mem_ok & i_mem_we) begin
				link.sw_we <= 1'b1;
				link.sw_addr <= {1'b0, i_mem_addr};
				link.sw_wdata <= i_mem_wdata;
			end
			case (state)
				h_idle: begin
					if (i_reset_req) begin
						link.bus_reset <= 1'b1;
						cur_addr <= 7'h00;
						step <= 3'h0;
						svc_ep <= 4'h0;
						o_busy <= 1'b1;
						state <= h_cfg;
					end else if (i_set_addr) begin
						cur_addr <= i_new_addr;
						link.sw_we <= 1'b1;
						link.sw_addr <= uep_pkg::REG_FN;
						link.sw_wdata <= {8'h00, 1'b1, i_new_addr};
					end else if (i_in_req & ~i_mem_we) begin
						link.tok_in_valid <= 1'b1;
						link.tok_addr <= cur_addr;
						link.tok_ep <= i_in_ep;
						svc_ep <= i_in_ep;
						first <= 1'b1;
						wait_cnt <= 8'h00;
						nak_probe <= 1'b0;
						o_busy <= 1'b1;
						state <= h_data;
					end
				end
				h_cfg: begin
					link.sw_we <= 1'b1;
					step <= step + 3'h1;
					case (step)
						3'h0: begin
							link.sw_addr <= uep_pkg::REG_FN;
							link.sw_wdata <= 16'h0080;
						end
						3'h1: begin
							link.sw_addr <= uep_pkg::REG_DESC;
							link.sw_wdata <= uep_pkg::HOST_DESC_BASE;
						end
						3'h2: begin
							link.sw_addr <= {1'b0, desc_w + uep_pkg::DESC_TX_PTR};
							link.sw_wdata <= uep_pkg::HOST_BUF0_PTR;
						end
						3'h3: begin
							link.sw_addr <= {1'b0, desc_w + uep_pkg::DESC_TX_CNT};
							link.sw_wdata <= {6'h00, i_len};
						end
						default: begin
							link.sw_addr <= uep_pkg::REG_EP_BASE;
							link.sw_wdata <= ctrl_base | 16'h0030;
							o_busy <= 1'b0;
							state <= h_idle;
						end
					endcase
				end
				h_data: begin
					wait_cnt <= wait_cnt + 8'h01;
					if (link.tx_valid) begin
						first <= 1'b0;
						wait_cnt <= 8'h00;
						o_rx_valid <= 1'b1;
						o_rx_byte <= link.tx_byte;
						if (first) begin
							o_pid <= link.tx_byte;
						end
						if (link.tx_last & ~first) begin
							link.hs_ack <= 1'b1;
							step <= 3'h0;
							state <= h_rdwait;
						end else if (link.tx_last) begin
							o_busy <= nak_probe;
							state <= nak_probe ? h_refill : h_idle;
						end
					end else if (wait_cnt == uep_pkg::HOST_TIMEOUT) begin
						o_busy <= nak_probe;
						state <= nak_probe ? h_refill : h_idle;
					end
				end
				h_rdwait: begin
					// status read issued on the first cycle after the ack, without waiting on the flag
					step <= step + 3'h1;
					if (step == 3'h0) begin
						link.sw_re <= 1'b1;
						link.sw_addr <= uep_pkg::REG_ISTR;
					end else begin
						state <= h_rd;
					end
				end
				h_rd: begin
					svc_ep <= {1'b0, link.sw_rdata[2:0]};
					state <= h_clear;
				end
				h_clear: begin
					link.sw_we <= 1'b1;
					link.sw_addr <= uep_pkg::REG_EP_BASE | {5'h00, svc_ep};
					link.sw_wdata <= svc_ctrl | 16'h0020;
					state <= h_refill;
				end
				h_refill: begin
					if (i_refill_done & ~i_mem_we) begin
						link.sw_we <= 1'b1;
						link.sw_addr <= {1'b0, desc_w + uep_pkg::DESC_TX_CNT};
						link.sw_wdata <= {6'h00, i_len};
						state <= h_count;
					end else if (i_in_req & ~i_mem_we) begin
						link.tok_in_valid <= 1'b1;
						link.tok_addr <= cur_addr;
						link.tok_ep <= i_in_ep;
						first <= 1'b1;
						wait_cnt <= 8'h00;
						nak_probe <= 1'b1;
						state <= h_data;
					end
				end
				h_count: begin
					link.sw_we <= 1'b1;
					link.sw_addr <= uep_pkg::REG_EP_BASE | {5'h00, svc_ep};
					link.sw_wdata <= svc_ctrl | 16'h00B0;
					o_serviced <= 1'b1;
					o_busy <= 1'b0;
					state <= h_idle;
				end
				default: begin
					state <= h_idle;
				end
			endcase
		end
	end
endmodule

/* File: tb/usb_link_asserts.sv */
// concurrent checks on the link between engine and host end
module usb_link_asserts (
	input wire logic        i_ref_clk,
	input wire logic        i_rst,
	input wire logic        bus_reset,
	input wire logic        tok_in_valid,
	input wire logic        hs_ack,
	input wire logic        tx_valid,
	input wire logic [7:0]  tx_byte,
	input wire logic        tx_last,
	input wire logic [8:0]  sw_addr,
	input wire logic [15:0] sw_wdata,
	input wire logic        sw_we,
	input wire logic        sw_re,
	input wire logic [15:0] sw_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [8:0] CNT_WORD = 9'h001;
	logic        in_frame;
	logic        is_data;
	logic [10:0] nbytes;
	logic [9:0]  cnt_exp;
	logic        fn_en;
	logic        tog;
	logic        flag_seen;
	logic        rst_seen;
	wire first   = tx_valid && !in_frame;
	wire pid_hs  = tx_byte == uep_pkg::PID_NAK || tx_byte == uep_pkg::PID_STALL;
	wire pid_dt  = tx_byte == uep_pkg::PID_DATA0 ||
		tx_byte == uep_pkg::PID_DATA1;
	wire istr_rd = sw_re && sw_addr == uep_pkg::REG_ISTR;
	wire istr_wr = sw_we && sw_addr == uep_pkg::REG_ISTR;
	wire fn_wr   = sw_we && sw_addr == uep_pkg::REG_FN;
	wire ep0_clr = sw_we && sw_addr == uep_pkg::REG_EP_BASE &&
		!sw_wdata[uep_pkg::EPC_FLAG];
	wire cnt_wr  = sw_we && sw_addr == CNT_WORD;

	// endpoint and function state as software and host see it
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || bus_reset) begin
			fn_en <= 1'b0;
			tog <= 1'b0;
			flag_seen <= 1'b0;
		end else begin
			if (fn_wr)
				fn_en <= sw_wdata[uep_pkg::FN_EN];
			if (hs_ack)
				tog <= !tog;
			if (ep0_clr)
				flag_seen <= 1'b0;
			else if (hs_ack)
				flag_seen <= 1'b1;
		end
	end

	// frame tracking and bus reset record
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			in_frame <= 1'b0;
			is_data <= 1'b0;
			nbytes <= 11'h000;
			cnt_exp <= 10'h000;
			rst_seen <= 1'b0;
		end else begin
			if (tx_valid)
				in_frame <= !tx_last;
			if (tx_valid)
				nbytes <= first ? 11'h001 : nbytes + 11'h001;
			if (first)
				is_data <= pid_dt;
			if (cnt_wr)
				cnt_exp <= sw_wdata[9:0];
			if (bus_reset)
				rst_seen <= 1'b1;
			else if (istr_wr && !sw_wdata[uep_pkg::ISTR_RST])
				rst_seen <= 1'b0;
		end
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	property p_silent_disabled;
		tok_in_valid && !fn_en |=> !tx_valid [*8];
	endproperty
	a_silent_disabled: assert property (p_silent_disabled)
		else $error("answer while function disabled");
	property p_rst_flag;
		istr_rd |=> sw_rdata[uep_pkg::ISTR_RST] == $past(rst_seen);
	endproperty
	a_rst_flag: assert property (p_rst_flag)
		else $error("bus reset status bit wrong");
	property p_first_pid;
		first |-> pid_dt || pid_hs;
	endproperty
	a_first_pid: assert property (p_first_pid)
		else $error("frame starts with unknown pid");
	property p_hs_single;
		first && pid_hs |-> tx_last;
	endproperty
	a_hs_single: assert property (p_hs_single)
		else $error("handshake not a single byte");
	property p_hs_timing;
		first && pid_hs |-> $past(tok_in_valid);
	endproperty
	a_hs_timing: assert property (p_hs_timing)
		else $error("handshake not one cycle after token");
	property p_toggle;
		first && pid_dt |-> tx_byte == (tog ? uep_pkg::PID_DATA1 :
			uep_pkg::PID_DATA0);
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("data pid does not follow toggle");
	property p_len;
		tx_valid && tx_last && !first && is_data |->
			nbytes == {1'b0, cnt_exp} + 11'h002;
	endproperty
	a_len: assert property (p_len)
		else $error("data frame length wrong");
	property p_ctr_status;
		istr_rd && flag_seen |=> sw_rdata[uep_pkg::ISTR_CTR] &&
			!sw_rdata[uep_pkg::ISTR_DIR] && sw_rdata[2:0] == 3'h0;
	endproperty
	a_ctr_status: assert property (p_ctr_status)
		else $error("interrupt status misses completion");

	c_data_end: cover property (tx_last && is_data && !first);
	c_ack: cover property (hs_ack);
	c_silent: cover property (tok_in_valid && !fn_en);
	c_ctr_read: cover property (istr_rd && flag_seen);
endmodule

/* File: tb/test_usb_endpoint_buffer_tx_engine.sv */
// bench for the endpoint engine and host end joined by the link
module test_usb_endpoint_buffer_tx_engine;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_ref_clk, i_rst, i_ce, i_reset_req, i_set_addr;
	logic [6:0]  i_new_addr;
	logic        i_in_req, i_mem_we, i_refill_done, irq_seen;
	logic [3:0]  i_in_ep;
	logic [9:0]  i_len;
	logic [7:0]  i_mem_addr;
	logic [15:0] i_mem_wdata;
	logic        o_busy, o_rx_valid, o_serviced, o_ep_irq;
	logic [7:0]  o_rx_byte, o_pid;
	logic [7:0]  rx_q[$], exp_q[$], pay[$];
	int          bad_count, tests_run;
	localparam logic [7:0] BUF_W = uep_pkg::HOST_BUF0_PTR[8:1];

	usb_link_if link();
	usb_ep_device i_usb_ep_device (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.i_ce(i_ce), .link(link), .o_ep_irq(o_ep_irq));
	usb_ep_host i_usb_ep_host (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.i_ce(i_ce), .link(link), .i_reset_req(i_reset_req),
		.i_set_addr(i_set_addr), .i_new_addr(i_new_addr),
		.i_in_req(i_in_req), .i_in_ep(i_in_ep), .i_len(i_len),
		.i_mem_we(i_mem_we), .i_mem_addr(i_mem_addr),
		.i_mem_wdata(i_mem_wdata), .i_refill_done(i_refill_done),
		.o_busy(o_busy), .o_rx_valid(o_rx_valid), .o_rx_byte(o_rx_byte),
		.o_pid(o_pid), .o_serviced(o_serviced));
	usb_link_asserts i_usb_link_asserts (.i_ref_clk(i_ref_clk),
		.i_rst(i_rst), .bus_reset(link.bus_reset),
		.tok_in_valid(link.tok_in_valid), .hs_ack(link.hs_ack),
		.tx_valid(link.tx_valid), .tx_byte(link.tx_byte),
		.tx_last(link.tx_last), .sw_addr(link.sw_addr),
		.sw_wdata(link.sw_wdata), .sw_we(link.sw_we), .sw_re(link.sw_re),
		.sw_rdata(link.sw_rdata));

	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = !i_ref_clk;
	end

	task automatic close_out();
		$display("compares %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic mem_wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_ref_clk);
		i_mem_addr <= a;
		i_mem_wdata <= d;
		i_mem_we <= 1'b1;
		@(posedge i_ref_clk);
		i_mem_we <= 1'b0;
	endtask

	task automatic wait_idle();
		for (int k = 0; k < 200; k++) begin
			@(posedge i_ref_clk) #1;
			if (o_busy === 1'b0)
				break;
		end
	endtask

	// expected frame: pid, payload, inverted crc low then high
	task automatic set_exp(input logic [7:0] pid);
		logic [15:0] c;
		c = uep_pkg::CRC_INIT;
		exp_q = {pid};
		foreach (pay[i]) begin
			exp_q.push_back(pay[i]);
			c = c ^ {8'h00, pay[i]};
			for (int b = 0; b < 8; b++)
				c = c[0] ? (c >> 1) ^ uep_pkg::CRC_POLY : c >> 1;
		end
		exp_q.push_back(~c[7:0]);
		exp_q.push_back(~c[15:8]);
	endtask

	task automatic run_in(input logic [3:0] ep);
		int idle;
		idle = 0;
		irq_seen = 1'b0;
		rx_q.delete();
		@(posedge i_ref_clk);
		i_in_ep <= ep;
		i_in_req <= 1'b1;
		@(posedge i_ref_clk);
		i_in_req <= 1'b0;
		for (int k = 0; k < 600 && idle < 90; k++) begin
			@(posedge i_ref_clk) #1;
			idle = (o_rx_valid === 1'b1) ? 0 : idle + 1;
			if (o_rx_valid === 1'b1)
				rx_q.push_back(o_rx_byte);
			if (o_ep_irq === 1'b1)
				irq_seen = 1'b1;
		end
		check(16'(rx_q.size()), 16'(exp_q.size()));
		foreach (exp_q[i])
			if (i < rx_q.size())
				check({8'h00, rx_q[i]}, {8'h00, exp_q[i]});
		if (exp_q.size() > 0)
			check({8'h00, o_pid}, {8'h00, exp_q[0]});
	endtask

	task automatic refill(input logic [15:0] w0, input logic [15:0] w1);
		logic seen;
		seen = 1'b0;
		mem_wr(BUF_W, w0);
		mem_wr(BUF_W + 8'h01, w1);
		@(posedge i_ref_clk);
		i_len <= 10'd4;
		i_refill_done <= 1'b1;
		@(posedge i_ref_clk);
		i_refill_done <= 1'b0;
		for (int k = 0; k < 100 && !seen; k++) begin
			@(posedge i_ref_clk) #1;
			seen = (o_serviced === 1'b1);
		end
		check({15'h0, seen}, 16'h0001);
		check({15'h0, o_ep_irq}, 16'h0000);
	endtask

	initial begin
		repeat (20000) @(posedge i_ref_clk);
		bad_count++;
		close_out();
	end

	initial begin
		{i_rst, i_ce} = 2'b11;
		{i_reset_req, i_set_addr, i_in_req, i_mem_we} = 4'h0;
		{i_refill_done, irq_seen} = 2'b00;
		i_new_addr = 7'h00;
		i_in_ep = 4'h0;
		i_len = 10'd5;
		i_mem_addr = 8'h00;
		i_mem_wdata = 16'h0000;
		bad_count = 0;
		tests_run = 0;
		repeat (16) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		mem_wr(BUF_W, 16'h2211);
		mem_wr(BUF_W + 8'h01, 16'h4433);
		mem_wr(BUF_W + 8'h02, 16'hEE55);
		exp_q.delete();
		run_in(4'h0);
		@(posedge i_ref_clk);
		i_reset_req <= 1'b1;
		@(posedge i_ref_clk);
		i_reset_req <= 1'b0;
		wait_idle();
		pay = {8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
		set_exp(uep_pkg::PID_DATA0);
		run_in(4'h0);
		check({15'h0, irq_seen}, 16'h0001);
		refill(16'hBBAA, 16'hDDCC);
		pay = {8'hAA, 8'hBB, 8'hCC, 8'hDD};
		set_exp(uep_pkg::PID_DATA1);
		run_in(4'h0);
		exp_q = {uep_pkg::PID_NAK};
		run_in(4'h0);
		refill(16'hBBAA, 16'hDDCC);
		@(posedge i_ref_clk);
		i_new_addr <= 7'h05;
		i_set_addr <= 1'b1;
		@(posedge i_ref_clk);
		i_set_addr <= 1'b0;
		wait_idle();
		set_exp(uep_pkg::PID_DATA0);
		run_in(4'h0);
		refill(16'hBBAA, 16'hDDCC);
		exp_q.delete();
		run_in(4'h2);
		close_out();
	end
endmodule
